// ---- hw/dsadc_seq_defs.svh ----
// Purpose: Constants for the delta-sigma converter sequencer
// Assumes: 100 MHz clock, register port with one-cycle read latency
// Notes:   Summary of operation follows
// Summary of operation
// - Start bit or trigger input starts conversion
// - Done flag holds until read; single-mode output holds until read
// - Single mode idles until trigger
// - Single: four conversions, result after fourth
// - After read, single returns to standby
// - Continuous: first result after three primes
// - Continuous: further results at sample rate
// - Multi: reset and re-prime between samples
// - Multi: next sample starts automatically
// - Output depends on last four samples
// - Mux change: invalid until fourth sample
// - Serial bit stream becomes parallel words
// - Fourth-order sinc response
// - 12-bit or 8-bit resolution, rate configurable
// - Completion by polling, interrupt or DMA
`ifndef DSADC_SEQ_DEFS_SVH
`define DSADC_SEQ_DEFS_SVH

`define ADDR_W         4
`define DATA_W         16
`define OFS_CTRL       4'h0
`define OFS_CFG        4'h1
`define OFS_STATUS     4'h2
`define OFS_RESULT     4'h3
`define OFS_IRQ_STAT   4'h4
`define OFS_IRQ_EN     4'h5
`define OFS_IRQ_CLR    4'h6
`define OFS_MUX        4'h7
// Control: bit0 start, bit1 stop
`define CTRL_START     0
`define CTRL_STOP      1
// Config: [1:0] mode, [2] 8-bit resolution, [15:8] decimation
`define CFG_MODE_LO    0
`define CFG_MODE_HI    1
`define CFG_RES8       2
`define CFG_DEC_LO     8
`define CFG_DEC_HI     15
`define CFG_RESET      16'h2003
// Status: bit0 done, bit1 busy, bit2 data valid
`define ST_DONE        0
`define ST_BUSY        1
`define ST_VALID       2
// Interrupt bits: bit0 done, bit1 overrun
`define IRQ_W          2
`define IRQ_DONE       0
`define IRQ_OVR        1
`define PRIME_FULL     2'h3
`define PRIME_TURBO    2'h1
`define MUX_W          4
`define SETTLE_CNT     3'h4
`define ACC_W          40
`define RES_SHIFT12    6'h1C
`define RES_SHIFT8     6'h20

`endif

// ---- hw/dsadc_seq_pkg.sv ----
// Purpose: Types for the delta-sigma converter sequencer
// Assumes: Constants live in the matching header
// Notes:   Mode codes follow the two-bit mode field
package dsadc_seq_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_CONTINUOUS,
    MODE_MULTI,
    MODE_TURBO
  } mode_type;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_CONVERT,
    ST_WAIT_READ
  } seq_state_type;
endpackage : dsadc_seq_pkg

// ---- hw/dsadc_seq.sv ----
// Purpose: Sequencer and sinc4 decimator for a delta-sigma converter
// Assumes: Modulator bit stream synchronous to i_clk, one bit per cycle
// Notes:   Registers at word indices; read data valid one cycle after strobe
`timescale 1ns/1ns
`include "dsadc_seq_defs.svh"

module dsadc_seq (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  // Register port
  input  wire logic [`ADDR_W-1:0] i_addr,
  input  wire logic [`DATA_W-1:0] i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [`DATA_W-1:0] o_rdata,
  // Converter side
  input  wire logic               i_mod_bit,
  input  wire logic               i_start_trig,
  input  wire logic               i_dma_ack,
  output logic      [`MUX_W-1:0]  o_mux_sel,
  output logic                    o_mod_reset,
  // Completion
  output logic                    o_done,
  output logic                    o_dma_req,
  output logic                    o_irq
);

  // Register file
  logic [`DATA_W-1:0] cfg_r;
  logic [`MUX_W-1:0]  mux_r;
  logic [`IRQ_W-1:0]  irq_stat_r;
  logic [`IRQ_W-1:0]  irq_en_r;
  logic [`DATA_W-1:0] result_r;
  logic [`DATA_W-1:0] rdata_r;
  logic               done_r;
  logic               valid_r;
  logic               irq_r;
  logic               mod_reset_r;

  // Sequencer
  dsadc_seq_pkg::seq_state_type state_r;
  dsadc_seq_pkg::seq_state_type state_nxt;
  logic [7:0]         dec_cnt_r;
  logic [1:0]         prime_r;
  logic [2:0]         settle_r;

  // Decimator, four integrators and four combs
  logic [`ACC_W-1:0]  integ_r [4];
  logic [`ACC_W-1:0]  comb_r  [4];
  logic [`ACC_W-1:0]  integ_in [4];
  logic [`ACC_W-1:0]  comb_in  [5];

  // Decode
  wire wr_ctrl    = i_wr && (i_addr == `OFS_CTRL);
  wire wr_cfg     = i_wr && (i_addr == `OFS_CFG);
  wire wr_mux     = i_wr && (i_addr == `OFS_MUX);
  wire wr_irq_en  = i_wr && (i_addr == `OFS_IRQ_EN);
  wire wr_irq_clr = i_wr && (i_addr == `OFS_IRQ_CLR);
  wire rd_result  = i_rd && (i_addr == `OFS_RESULT);
  wire sw_start   = wr_ctrl && i_wdata[`CTRL_START];
  wire sw_stop    = wr_ctrl && i_wdata[`CTRL_STOP];
  wire start_req  = sw_start || i_start_trig;
  // Either reader may take the result; both end the wait
  wire rd_taken   = rd_result;
  wire dma_taken  = done_r && i_dma_ack;
  wire result_taken = rd_taken || dma_taken;

  wire [1:0] mode_bits = cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
  dsadc_seq_pkg::mode_type mode;
  assign mode = dsadc_seq_pkg::mode_type'(mode_bits);

  // State and mode flags, decoded once and shared
  wire in_standby = (state_r == dsadc_seq_pkg::ST_STANDBY);
  wire in_convert = (state_r == dsadc_seq_pkg::ST_CONVERT);
  wire is_single  = (mode == dsadc_seq_pkg::MODE_SINGLE);
  wire is_multi   = (mode == dsadc_seq_pkg::MODE_MULTI);
  wire is_turbo   = (mode == dsadc_seq_pkg::MODE_TURBO);

  wire res8       = cfg_r[`CFG_RES8];
  wire [7:0] dec_len = cfg_r[`CFG_DEC_HI:`CFG_DEC_LO];
  wire conv_end   = in_convert && (dec_cnt_r == dec_len);
  wire primed     = (prime_r == 2'h0);
  wire multi_like = is_multi || is_turbo;
  // Turbo trades settling for rate: one priming conversion only
  wire [1:0] prime_load = is_turbo ? `PRIME_TURBO : `PRIME_FULL;
  wire result_evt = conv_end && primed;
  wire restart    = start_req && in_standby;

  // Fourth-order sinc: cascaded integrators on the bit stream, combs at decimation
  // Accumulator width covers the growth of four stages at the longest period
  assign integ_in[0] = {{(`ACC_W-1){1'b0}}, i_mod_bit};
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sinc
      if (g < 3) begin : g_link
        assign integ_in[g+1] = integ_r[g];
      end
      assign comb_in[g+1] = comb_in[g] - comb_r[g];
      // Integrators run every clock on the raw bit stream
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          integ_r[g] <= '0;
        end else if (mod_reset_r) begin
          integ_r[g] <= '0;
        end else begin
          integ_r[g] <= integ_r[g] + integ_in[g];
        end
      end
      // Combs only move at the end of each conversion period
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          comb_r[g] <= '0;
        end else if (mod_reset_r) begin
          comb_r[g] <= '0;
        end else if (conv_end) begin
          comb_r[g] <= comb_in[g];
        end
      end
    end
  endgenerate
  assign comb_in[0] = integ_r[3];

  // Scaling drops the filter growth so the word lands in the low bits
  wire [5:0]         res_shift = res8 ? `RES_SHIFT8 : `RES_SHIFT12;
  wire [`ACC_W-1:0]  scaled    = comb_in[4] >> res_shift;
  wire [`DATA_W-1:0] new_result = scaled[`DATA_W-1:0];

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dsadc_seq_pkg::ST_STANDBY: begin
        if (start_req) begin
          state_nxt = dsadc_seq_pkg::ST_CONVERT;
        end
      end
      dsadc_seq_pkg::ST_CONVERT: begin
        if (sw_stop) begin
          state_nxt = dsadc_seq_pkg::ST_STANDBY;
        end else if (result_evt && is_single) begin
          state_nxt = dsadc_seq_pkg::ST_WAIT_READ;
        end
      end
      dsadc_seq_pkg::ST_WAIT_READ: begin
        if (result_taken || sw_stop) begin
          state_nxt = dsadc_seq_pkg::ST_STANDBY;
        end
      end
      default: state_nxt = dsadc_seq_pkg::ST_STANDBY;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= dsadc_seq_pkg::ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Conversion period counter; a period is the length plus one
  // A length shrunk mid-period wraps once through the full count
  logic [7:0] dec_cnt_nxt;
  assign dec_cnt_nxt = (restart || conv_end || !in_convert) ? 8'h00 :
                       dec_cnt_r + 8'h01;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dec_cnt_r <= 8'h00;
    end else begin
      dec_cnt_r <= dec_cnt_nxt;
    end
  end

  // Priming: single and multi re-prime every sample, continuous once
  logic [1:0] prime_nxt;
  assign prime_nxt = (restart || (result_evt && multi_like)) ? prime_load :
                     (conv_end && !primed)                  ? prime_r - 2'h1 :
                     prime_r;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prime_r <= `PRIME_FULL;
    end else begin
      prime_r <= prime_nxt;
    end
  end

  // Modulator and decimator clear between multi samples; it keeps one
  // sample's residue out of the next when the mux moves between them
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mod_reset_r <= 1'b1;
    end else begin
      mod_reset_r <= restart || (result_evt && multi_like);
    end
  end

  // Mux change invalidates data until fourth conversion after it
  // Count starts full after reset too: nothing has settled yet
  logic [2:0] settle_nxt;
  assign settle_nxt = wr_mux                         ? `SETTLE_CNT :
                      (conv_end && settle_r != 3'h0) ? settle_r - 3'h1 :
                      settle_r;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      settle_r <= `SETTLE_CNT;
    end else begin
      settle_r <= settle_nxt;
    end
  end

  wire settle_ok = (settle_r == 3'h0) || (conv_end && settle_r == 3'h1);

  // Result word, loaded only at a primed conversion end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      result_r <= '0;
    end else if (result_evt) begin
      result_r <= new_result;
    end
  end

  // Done holds until a read or acknowledge; a new result beats a same-cycle read
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      done_r <= 1'b0;
    end else if (result_evt) begin
      done_r <= 1'b1;
    end else if (result_taken) begin
      done_r <= 1'b0;
    end
  end

  // A mux write drops valid at once, not at the next result
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      valid_r <= 1'b0;
    end else if (wr_mux) begin
      valid_r <= 1'b0;
    end else if (result_evt) begin
      valid_r <= settle_ok;
    end
  end

  // Interrupt status per bit: an event set wins over a same-cycle clear
  wire [`IRQ_W-1:0] irq_set = {result_evt && done_r, result_evt};
  wire [`IRQ_W-1:0] irq_clr = wr_irq_clr ? i_wdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  logic [`IRQ_W-1:0] irq_stat_nxt;
  generate
    for (g = 0; g < `IRQ_W; g = g + 1) begin : g_irq
      assign irq_stat_nxt[g] = irq_set[g] || (irq_stat_r[g] && !irq_clr[g]);
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Interrupt enable, same layout as the status
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_en_r <= '0;
    end else if (wr_irq_en) begin
      irq_en_r <= i_wdata[`IRQ_W-1:0];
    end
  end

  // Registered so the pin comes straight from a flop, one cycle late
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_r <= `CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= i_wdata;
    end
  end

  // Software keeps this fixed while a continuous run is active
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mux_r <= '0;
    end else if (wr_mux) begin
      mux_r <= i_wdata[`MUX_W-1:0];
    end
  end

  // Read words; write-only and unmapped indices read as zero
  wire               busy        = !in_standby;
  wire [`DATA_W-1:0] status_word = {{(`DATA_W-3){1'b0}}, valid_r, busy, done_r};
  wire [`DATA_W-1:0] irq_stat_wd = {{(`DATA_W-`IRQ_W){1'b0}}, irq_stat_r};
  wire [`DATA_W-1:0] irq_en_wd   = {{(`DATA_W-`IRQ_W){1'b0}}, irq_en_r};
  wire [`DATA_W-1:0] mux_wd      = {{(`DATA_W-`MUX_W){1'b0}}, mux_r};
  wire               sel_cfg     = (i_addr == `OFS_CFG);
  wire               sel_status  = (i_addr == `OFS_STATUS);
  wire               sel_result  = (i_addr == `OFS_RESULT);
  wire               sel_irq_st  = (i_addr == `OFS_IRQ_STAT);
  wire               sel_irq_en  = (i_addr == `OFS_IRQ_EN);
  wire               sel_mux     = (i_addr == `OFS_MUX);
  logic [`DATA_W-1:0] rd_mux;
  assign rd_mux = sel_cfg    ? cfg_r :
                  sel_status ? status_word :
                  sel_result ? result_r :
                  sel_irq_st ? irq_stat_wd :
                  sel_irq_en ? irq_en_wd :
                  sel_mux    ? mux_wd :
                  '0;

  // Read data, one cycle after the strobe; zero between reads
  logic [`DATA_W-1:0] rdata_nxt;
  assign rdata_nxt = i_rd ? rd_mux : '0;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs, each straight from its flop
  // DMA request mirrors done; the acknowledge ends both
  assign o_rdata     = rdata_r;
  assign o_done      = done_r;
  assign o_dma_req   = done_r;
  assign o_irq       = irq_r;
  assign o_mux_sel   = mux_r;
  assign o_mod_reset = mod_reset_r;

endmodule : dsadc_seq

// ---- tb/dsadc_seq_asserts.sv ----
// Purpose: Port checks for the converter sequencer
// Assumes: One clock, reset active high
// Notes:   Done drops only on a read or acknowledge; the check also allows a control write
`timescale 1ns/1ns
`include "dsadc_seq_defs.svh"
module dsadc_seq_asserts (
  // Clock and reset
  input wire logic               i_clk,
  input wire logic               i_reset,
  // Register port
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [`DATA_W-1:0] i_wdata,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire logic [`DATA_W-1:0] o_rdata,
  // Converter side
  input wire logic               i_mod_bit,
  input wire logic               i_start_trig,
  input wire logic               i_dma_ack,
  input wire logic [`MUX_W-1:0]  o_mux_sel,
  input wire logic               o_mod_reset,
  // Completion
  input wire logic               o_done,
  input wire logic               o_dma_req,
  input wire logic               o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_mux_wr; i_wr && i_addr == `OFS_MUX; endsequence
  sequence s_stat_rd; i_rd && i_addr == `OFS_STATUS; endsequence
  a_dma_mirror: assert property (o_dma_req == o_done)
    else $error("dma request differs from done");
  a_done_fall_cause: assert property ($fell(o_done) |-> $past(i_dma_ack) ||
    ($past(i_wr) && $past(i_addr) == `OFS_CTRL) || ($past(i_rd) && $past(i_addr) == `OFS_RESULT))
    else $error("done fell without read or ack");
  a_status_done: assert property (s_stat_rd |=> o_rdata[`ST_DONE] == $past(o_done))
    else $error("status done bit differs from done");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read");
  a_mux_write: assert property (s_mux_wr |=> o_mux_sel == $past(i_wdata[`MUX_W-1:0]))
    else $error("mux select not updated");
  a_valid_drop: assert property (s_mux_wr ##[1:2] s_stat_rd |=> !o_rdata[`ST_VALID])
    else $error("valid right after mux change");
  a_no_early_done: assert property ($rose(o_done) |-> !$past(o_mod_reset) && !$past(o_mod_reset, 2))
    else $error("done too soon after clear");
  a_clear_pulse: assert property ($rose(o_mod_reset) |=> !o_mod_reset)
    else $error("clear pulse longer than one cycle");
endmodule : dsadc_seq_asserts

bind dsadc_seq dsadc_seq_asserts u_chk (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_mod_bit, .i_start_trig, .i_dma_ack, .o_mux_sel, .o_mod_reset, .o_done, .o_dma_req, .o_irq);

// ---- tb/dsadc_dma_model.sv ----
// Purpose: Far side: result reader and modulator bit source
// Assumes: Ack is a one-cycle pulse
// Notes:   i_lag sets a prompt or slow reader
`timescale 1ns/1ns
module dsadc_dma_model (
  // Clock and control
  input  wire logic       i_clk,
  input  wire logic       i_en,
  input  wire logic [3:0] i_lag,
  // Converter side
  input  wire logic       i_req,
  output logic            o_ack = 1'b0,
  output logic            o_mod_bit
);
  logic [3:0] wait_r = 4'h0;
  logic [4:0] lfsr_r = 5'h1F;
  always @(posedge i_clk) begin
    lfsr_r <= {lfsr_r[3:0], lfsr_r[4] ^ lfsr_r[2]};
    o_ack <= 1'b0;
    if (i_en && i_req && !o_ack) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r >= i_lag) begin
        o_ack <= 1'b1;
        wait_r <= 4'h0;
      end
    end
  end
  assign o_mod_bit = lfsr_r[0];
endmodule : dsadc_dma_model

// ---- tb/dsadc_seq_tb.sv ----
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Conversion length 3, so a period of 4 cycles
// Notes:   Reset checks first, then mode rows, then register and interrupt cases
`timescale 1ns/1ns
`include "dsadc_seq_defs.svh"
module dsadc_seq_tb;
  typedef struct {logic [1:0] mode; bit pin; int first; int gap;} row_type;
  localparam int P = 4;
  logic               i_clk, i_reset, i_wr, i_rd, i_start_trig, dma_en;
  logic               o_mod_reset, o_done, o_dma_req, o_irq, i_dma_ack, i_mod_bit;
  logic [`ADDR_W-1:0] i_addr;
  logic [`DATA_W-1:0] i_wdata, o_rdata, rd_val;
  logic [`MUX_W-1:0]  o_mux_sel;
  logic [3:0]         lag;
  int                 err_total, checked, t, t2;
  row_type            rows [4] = '{'{dsadc_seq_pkg::MODE_SINGLE, 1, 4, 0},
    '{dsadc_seq_pkg::MODE_CONTINUOUS, 0, 4, 1}, '{dsadc_seq_pkg::MODE_MULTI, 1, 4, 4},
    '{dsadc_seq_pkg::MODE_TURBO, 0, 2, 2}};
  dsadc_seq dut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_mod_bit,
    .i_start_trig, .i_dma_ack, .o_mux_sel, .o_mod_reset, .o_done, .o_dma_req, .o_irq);
  dsadc_dma_model host (.i_clk, .i_en(dma_en), .i_lag(lag), .i_req(o_dma_req), .o_ack(i_dma_ack),
    .o_mod_bit(i_mod_bit));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [`ADDR_W-1:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask : rd
  task automatic start(input bit pin);
    if (pin) begin
      @(posedge i_clk);
      i_start_trig <= 1'b1;
      @(posedge i_clk);
      i_start_trig <= 1'b0;
    end else begin
      wr(`OFS_CTRL, 16'h0001);
    end
  endtask : start
  // Counts edges until done reaches the level; bounded so a hang shows
  task automatic wait_lvl(input logic lvl);
    t = 0;
    #1;
    while (o_done !== lvl && t < 400) begin
      @(posedge i_clk);
      #1 t++;
    end
  endtask : wait_lvl
  task automatic chk(input logic [`DATA_W-1:0] g, input logic [`DATA_W-1:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic chk_n(input int g, input int lo, input int hi);
    checked++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask : chk_n
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #60000;
    err_total++;
    final_report();
  end
  initial begin
    {i_reset, i_wr, i_rd, i_start_trig, dma_en, lag, i_addr, i_wdata} = '0;
    i_reset = 1'b1;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(`OFS_CFG);
    chk(rd_val, `CFG_RESET);
    rd(4'hF);
    chk(rd_val, 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(`OFS_CFG, {8'h03, 6'h00, rows[i].mode});
      dma_en <= (rows[i].gap != 0);
      lag <= (i == 2) ? 4'h9 : 4'h1;
      start(rows[i].pin);
      wait_lvl(1'b1);
      chk_n(t, rows[i].first * P, rows[i].first * P + 4);
      if (rows[i].gap == 0) begin
        rd(`OFS_RESULT);
        chk({15'h0, o_done}, 16'h0000);
        repeat (5 * P) @(posedge i_clk);
        chk({15'h0, o_done}, 16'h0000);
      end else begin
        wait_lvl(1'b0);
        t2 = t;
        wait_lvl(1'b1);
        chk_n(t + t2, rows[i].gap * P, rows[i].gap * P + (rows[i].gap > 1 ? 4 : 0));
        wr(`OFS_CTRL, 16'h0002);
        dma_en <= 1'b0;
        repeat (6 * P) @(posedge i_clk);
        rd(`OFS_RESULT);
      end
      $display("row %0d done", i);
    end
    // Mux moves only once continuous runs have stopped
    wr(`OFS_MUX, 16'h0005);
    rd(`OFS_STATUS);
    chk(rd_val & 16'h0004, 16'h0000);
    rd(`OFS_MUX);
    chk(rd_val, 16'h0005);
    wr(`OFS_IRQ_EN, 16'h0001);
    wr(`OFS_IRQ_CLR, 16'h0003);
    rd(`OFS_IRQ_STAT);
    chk(rd_val, 16'h0000);
    chk({15'h0, o_irq}, 16'h0000);
    wr(`OFS_CFG, 16'h0300);
    start(1'b0);
    wait_lvl(1'b1);
    rd(`OFS_STATUS);
    chk(rd_val & 16'h0005, 16'h0005);
    chk({15'h0, o_irq}, 16'h0001);
    rd(`OFS_RESULT);
    wr(`OFS_IRQ_EN, 16'h0000);
    rd(`OFS_IRQ_STAT);
    chk({15'h0, o_irq}, 16'h0000);
    chk(rd_val & 16'h0001, 16'h0001);
    wr(`OFS_IRQ_CLR, 16'h0001);
    rd(`OFS_IRQ_STAT);
    chk(rd_val & 16'h0001, 16'h0000);
    $display("interrupt test done");
    final_report();
  end
endmodule : dsadc_seq_tb
